// ---- common/cag_pkg.sv ----
package cag_pkg;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned NPROF = 4;
  localparam int unsigned PROF_W = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_GAIN0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GAIN1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_GAIN2 = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_GAIN3 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

  localparam int unsigned CTRL_SOFT_RST_BIT = 5;
  localparam int unsigned CTRL_PROF_LSB = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_PROF_LSB = 4;
  localparam int unsigned STAT_GAIN_LSB = 8;

  localparam logic [GAIN_W-1:0] GAIN_RST = 8'h00;
  localparam logic [PROF_W-1:0] PROF_RST = 2'h0;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SCLK_HALF_NS = 16;
  localparam int unsigned HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STABLE_CYC = 48;
  localparam int unsigned XFER_MAX_CYC = 200;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_BIT_LO = 3'b010,
    ST_BIT_HI = 3'b011,
    ST_TRAIL = 3'b100
  } cag_state_t;
endpackage

// ---- src/cag_gain_writer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cag_gain_writer (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [cag_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [cag_pkg::DATA_W-1:0] PWDATA_I,
  output logic [cag_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [cag_pkg::PROF_W-1:0] PROFILE_I,
  output logic AMP_WRITE_STROBE_N_O,
  output logic AMP_SCLK_O,
  output logic AMP_SDATA_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_mapped(input logic [cag_pkg::ADDR_W-1:0] a);
    addr_mapped = (a == cag_pkg::ADDR_CTRL) || (a == cag_pkg::ADDR_GAIN0) ||
                  (a == cag_pkg::ADDR_GAIN1) || (a == cag_pkg::ADDR_GAIN2) ||
                  (a == cag_pkg::ADDR_GAIN3) || (a == cag_pkg::ADDR_STATUS);
  endfunction

  function automatic logic [cag_pkg::PROF_W-1:0] gain_index(input logic [cag_pkg::ADDR_W-1:0] a);
    logic [cag_pkg::ADDR_W-1:0] d;
    d = a - cag_pkg::ADDR_GAIN0;
    gain_index = d[cag_pkg::PROF_W+1:2];
  endfunction

  function automatic logic is_gain_addr(input logic [cag_pkg::ADDR_W-1:0] a);
    is_gain_addr = (a == cag_pkg::ADDR_GAIN0) || (a == cag_pkg::ADDR_GAIN1) ||
                   (a == cag_pkg::ADDR_GAIN2) || (a == cag_pkg::ADDR_GAIN3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam int unsigned DEB_W = 7;
  localparam int unsigned TMR_W = 4;
  localparam logic [DEB_W-1:0] DEB_DONE = DEB_W'(cag_pkg::STABLE_CYC);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(cag_pkg::HALF_CYC - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;

  logic [cag_pkg::PROF_W-1:0] prof_s1_r;
  logic [cag_pkg::PROF_W-1:0] prof_s2_r;
  logic [cag_pkg::GAIN_W-1:0] gain_r [cag_pkg::NPROF];
  logic [cag_pkg::GAIN_W-1:0] gain_nxt [cag_pkg::NPROF];
  logic [cag_pkg::PROF_W-1:0] swprof_r, swprof_nxt;
  logic [cag_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
  logic [cag_pkg::GAIN_W-1:0] seen_r, seen_nxt;
  logic [DEB_W-1:0] deb_r, deb_nxt;
  logic [cag_pkg::GAIN_W-1:0] applied_r, applied_nxt;
  logic pend_r, pend_nxt;
  cag_pkg::cag_state_t state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [cag_pkg::GAIN_W-1:0] shift_r, shift_nxt;
  logic strobe_n_r, strobe_n_nxt;
  logic sclk_r, sclk_nxt;
  logic sdata_r, sdata_nxt;

  logic [cag_pkg::PROF_W-1:0] eff_prof;
  logic [cag_pkg::GAIN_W-1:0] target;
  logic wr_acc;
  logic soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_mapped(PADDR_I);
  assign PRDATA_O = prdata_r;
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & addr_mapped(PADDR_I);
  assign soft_rst = wr_acc && (PADDR_I == cag_pkg::ADDR_CTRL) && PWDATA_I[cag_pkg::CTRL_SOFT_RST_BIT];

  // pins combined with software select bits
  assign eff_prof = prof_s2_r ^ swprof_r;
  assign target = gain_r[eff_prof];

  always_comb begin
    for (int i = 0; i < cag_pkg::NPROF; i++) begin
      gain_nxt[i] = gain_r[i];
    end
    swprof_nxt = swprof_r;
    prdata_nxt = prdata_r;
    if (soft_rst) begin
      for (int i = 0; i < cag_pkg::NPROF; i++) begin
        gain_nxt[i] = cag_pkg::GAIN_RST;
      end
      swprof_nxt = cag_pkg::PROF_RST;
    end else if (wr_acc) begin
      if (PADDR_I == cag_pkg::ADDR_CTRL) begin
        swprof_nxt = PWDATA_I[cag_pkg::CTRL_PROF_LSB +: cag_pkg::PROF_W];
      end else if (is_gain_addr(PADDR_I)) begin
        gain_nxt[gain_index(PADDR_I)] = PWDATA_I[cag_pkg::GAIN_W-1:0];
      end
    end
    if (PSEL_I && !PENABLE_I) begin
      prdata_nxt = '0;
      if (PADDR_I == cag_pkg::ADDR_CTRL) begin
        prdata_nxt[cag_pkg::CTRL_PROF_LSB +: cag_pkg::PROF_W] = swprof_r;
      end else if (is_gain_addr(PADDR_I)) begin
        prdata_nxt[cag_pkg::GAIN_W-1:0] = gain_r[gain_index(PADDR_I)];
      end else if (PADDR_I == cag_pkg::ADDR_STATUS) begin
        prdata_nxt[cag_pkg::STAT_BUSY_BIT] = (state_r != cag_pkg::ST_IDLE);
        prdata_nxt[cag_pkg::STAT_PROF_LSB +: cag_pkg::PROF_W] = eff_prof;
        prdata_nxt[cag_pkg::STAT_GAIN_LSB +: cag_pkg::GAIN_W] = applied_r;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < cag_pkg::NPROF; i++) begin
        gain_r[i] <= cag_pkg::GAIN_RST;
      end
      swprof_r <= cag_pkg::PROF_RST;
      prdata_r <= '0;
      prof_s1_r <= cag_pkg::PROF_RST;
      prof_s2_r <= cag_pkg::PROF_RST;
    end else if (CE_I) begin
      gain_r <= gain_nxt;
      swprof_r <= swprof_nxt;
      prdata_r <= prdata_nxt;
      prof_s1_r <= PROFILE_I;
      prof_s2_r <= prof_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger and debounce

  always_comb begin
    seen_nxt = target;
    deb_nxt = deb_r;
    if (target != seen_r) begin
      deb_nxt = '0;
    end else if (deb_r != DEB_DONE) begin
      deb_nxt = deb_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial writer

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    strobe_n_nxt = strobe_n_r;
    sclk_nxt = sclk_r;
    sdata_nxt = sdata_r;
    applied_nxt = applied_r;
    pend_nxt = pend_r;
    if (state_r != cag_pkg::ST_IDLE) begin
      tmr_nxt = (tmr_r == TMR_LAST) ? '0 : tmr_r + 1'b1;
    end
    case (state_r)
      cag_pkg::ST_IDLE: begin
        // mismatch against applied gain covers profile, gain and soft-reset triggers
        if (deb_r == DEB_DONE && target == seen_r && (target != applied_r || pend_r)) begin
          state_nxt = cag_pkg::ST_LEAD;
          strobe_n_nxt = 1'b0;
          shift_nxt = target;
          applied_nxt = target;
          pend_nxt = 1'b0;
          tmr_nxt = '0;
          bit_nxt = '0;
        end
      end
      cag_pkg::ST_LEAD: begin
        if (tmr_r == TMR_LAST) begin
          state_nxt = cag_pkg::ST_BIT_LO;
          sdata_nxt = shift_r[cag_pkg::GAIN_W-1];
        end
      end
      cag_pkg::ST_BIT_LO: begin
        if (tmr_r == TMR_LAST) begin
          state_nxt = cag_pkg::ST_BIT_HI;
          sclk_nxt = 1'b1;
        end
      end
      cag_pkg::ST_BIT_HI: begin
        if (tmr_r == TMR_LAST) begin
          sclk_nxt = 1'b0;
          if (bit_r == BIT_LAST) begin
            state_nxt = cag_pkg::ST_TRAIL;
          end else begin
            state_nxt = cag_pkg::ST_BIT_LO;
            bit_nxt = bit_r + 1'b1;
            shift_nxt = {shift_r[cag_pkg::GAIN_W-2:0], 1'b0};
            sdata_nxt = shift_r[cag_pkg::GAIN_W-2];
          end
        end
      end
      cag_pkg::ST_TRAIL: begin
        if (tmr_r == TMR_LAST) begin
          state_nxt = cag_pkg::ST_IDLE;
          strobe_n_nxt = 1'b1;
          sdata_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = cag_pkg::ST_IDLE;
        strobe_n_nxt = 1'b1;
        sclk_nxt = 1'b0;
        sdata_nxt = 1'b0;
      end
    endcase
    // no abort path: triggers are only looked at in idle
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      seen_r <= cag_pkg::GAIN_RST;
      deb_r <= '0;
      applied_r <= cag_pkg::GAIN_RST;
      pend_r <= 1'b1;
      state_r <= cag_pkg::ST_IDLE;
      tmr_r <= '0;
      bit_r <= '0;
      shift_r <= cag_pkg::GAIN_RST;
      strobe_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
    end else if (CE_I) begin
      seen_r <= seen_nxt;
      deb_r <= deb_nxt;
      applied_r <= applied_nxt;
      pend_r <= pend_nxt;
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      strobe_n_r <= strobe_n_nxt;
      sclk_r <= sclk_nxt;
      sdata_r <= sdata_nxt;
    end
  end

  assign AMP_WRITE_STROBE_N_O = strobe_n_r;
  assign AMP_SCLK_O = sclk_r;
  assign AMP_SDATA_O = sdata_r;

endmodule
`default_nettype wire

// ---- test/cag_gain_writer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cag_chk (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [cag_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic PSLVERR_O,
  input wire logic AMP_WRITE_STROBE_N_O,
  input wire logic AMP_SCLK_O,
  input wire logic AMP_SDATA_O
);
  logic [7:0] low_r, low_nxt;
  logic [3:0] pls_r, pls_nxt;
  logic sclk_d_r;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // cycles the strobe has been low and serial clock rises seen in this frame
  always_comb begin
    low_nxt = AMP_WRITE_STROBE_N_O ? 8'h00 : low_r + 8'h01;
    pls_nxt = AMP_WRITE_STROBE_N_O ? 4'h0 : pls_r + {3'h0, AMP_SCLK_O & ~sclk_d_r};
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      low_r <= 8'h00;
      pls_r <= 4'h0;
      sclk_d_r <= 1'b0;
    end else begin
      low_r <= low_nxt;
      pls_r <= pls_nxt;
      sclk_d_r <= AMP_SCLK_O;
    end
  end
  chk_frame_len: assert property ($rose(AMP_WRITE_STROBE_N_O) |-> low_r == 8'h48)
    else $error("write frame length wrong");
  chk_bit_count: assert property ($rose(AMP_WRITE_STROBE_N_O) |-> pls_r == 4'h8)
    else $error("serial clock pulse count wrong");
  chk_sclk_framed: assert property (AMP_SCLK_O |-> !AMP_WRITE_STROBE_N_O)
    else $error("serial clock outside frame");
  chk_idle_data: assert property (AMP_WRITE_STROBE_N_O |-> !AMP_SDATA_O)
    else $error("serial data not low when idle");
  chk_data_setup: assert property ($rose(AMP_SCLK_O) |-> $stable(AMP_SDATA_O))
    else $error("serial data moved at clock rise");
  chk_sclk_half: assert property ($rose(AMP_SCLK_O) |-> AMP_SCLK_O [*4] ##1 !AMP_SCLK_O)
    else $error("serial clock high time wrong");
  chk_reset_send: assert property ($rose(RST_N_I) |-> ##[48:64] $fell(AMP_WRITE_STROBE_N_O))
    else $error("no write after reset");
  chk_unmapped_err: assert property (PSEL_I && PENABLE_I && PADDR_I == 8'h18 |-> PSLVERR_O)
    else $error("unmapped access without error");
  cover property ($fell(AMP_WRITE_STROBE_N_O));
  cover property ($rose(AMP_SCLK_O));
  cover property (PSEL_I && PENABLE_I && PSLVERR_O);
endmodule
bind cag_gain_writer cag_chk u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O), .AMP_WRITE_STROBE_N_O(AMP_WRITE_STROBE_N_O),
  .AMP_SCLK_O(AMP_SCLK_O), .AMP_SDATA_O(AMP_SDATA_O));
`default_nettype wire

// ---- test/cag_amp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cag_amp_model (
  input wire logic strobe_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic [7:0] word_o,
  output int unsigned words_o
);
  logic [7:0] sh_r = 8'h00;
  int unsigned nb_r = 0;
  initial word_o = 8'h00;
  initial words_o = 0;
  always @(posedge sclk_i) begin
    if (!strobe_n_i) begin
      sh_r = {sh_r[6:0], sdata_i};
      nb_r = nb_r + 1;
    end
  end
  // a gain is taken only when the enable ends after exactly one byte
  always @(posedge strobe_n_i) begin
    if (nb_r == 8) begin
      word_o = sh_r;
      words_o = words_o + 1;
    end
    nb_r = 0;
  end
endmodule
`default_nettype wire

// ---- test/test_cag_gain_writer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_cag_gain_writer;
  logic MCLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0;
  logic [1:0] PROFILE_I = 2'h0;
  logic CE_I = 1'b1;
  logic [31:0] PRDATA_O;
  logic PREADY_O, PSLVERR_O, AMP_WRITE_STROBE_N_O, AMP_SCLK_O, AMP_SDATA_O;
  logic [7:0] word;
  int unsigned words;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  cag_gain_writer DUT (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .PROFILE_I(PROFILE_I), .AMP_WRITE_STROBE_N_O(AMP_WRITE_STROBE_N_O),
    .AMP_SCLK_O(AMP_SCLK_O), .AMP_SDATA_O(AMP_SDATA_O));
  cag_amp_model amp (.strobe_n_i(AMP_WRITE_STROBE_N_O), .sclk_i(AMP_SCLK_O), .sdata_i(AMP_SDATA_O),
    .word_o(word), .words_o(words));
  initial begin
    forever #2 MCLK_I = ~MCLK_I;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge MCLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge MCLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check("read data", exp, q);
    check("bus error", {31'h0, a == 8'h18}, {31'h0, e});
  endtask
  task automatic expect_word(input logic [7:0] g, input int lo);
    int unsigned n0;
    int t;
    n0 = words;
    t = 0;
    while (words == n0 && t < 200) begin
      @(posedge MCLK_I);
      t++;
    end
    check("transfer count", n0 + 1, words);
    check("gain word", {24'h0, g}, {24'h0, word});
    check("early transfer", 1, t >= lo);
  endtask
  task automatic expect_none();
    int unsigned n0;
    n0 = words;
    repeat (200) @(posedge MCLK_I);
    check("spurious transfer", n0, words);
  endtask
  task automatic t_reset();
    expect_word(8'h00, 120);
    for (int i = 1; i <= 4; i++) rd(8'(4 * i), 32'h0);
  endtask
  task automatic t_gain_write();
    wr(8'h04, 32'hFFFF_FFA5);
    expect_word(8'hA5, 120);
    rd(8'h04, 32'h0000_00A5);
  endtask
  task automatic t_profile();
    wr(8'h0C, 32'h3C);
    expect_none();
    PROFILE_I <= 2'h2;
    expect_word(8'h3C, 120);
    rd(8'h14, 32'h0000_3C20);
    wr(8'h00, 32'h2);
    expect_word(8'hA5, 120);
  endtask
  task automatic t_no_abort();
    int t;
    wr(8'h04, 32'h11);
    t = 0;
    while (AMP_WRITE_STROBE_N_O !== 1'b0 && t < 100) begin
      @(posedge MCLK_I);
      t++;
    end
    wr(8'h04, 32'h22);
    expect_word(8'h11, 0);
    expect_word(8'h22, 0);
  endtask
  task automatic t_soft_reset();
    wr(8'h00, 32'h20);
    expect_word(8'h00, 120);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h20);
    expect_none();
    rd(8'h18, 32'h0);
  endtask
  // a write issued while the clock enable is low must leave no trace
  task automatic t_freeze();
    CE_I <= 1'b0;
    wr(8'h04, 32'h77);
    CE_I <= 1'b1;
    rd(8'h04, 32'h0);
    expect_none();
  endtask
  initial begin
    repeat (20) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    t_reset();
    t_gain_write();
    t_profile();
    t_no_abort();
    t_soft_reset();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
